// File: rtl/ppbs_defines.svh
`ifndef PPBS_DEFINES_SVH
`define PPBS_DEFINES_SVH

// Number of downstream ports
`define PPBS_NUM_PORTS 4
// Strap sample delay after reset release, in clock cycles
`define PPBS_STRAP_WAIT 4'h3
// Serial clock divider: half period of the serial clock in clock cycles, minus one
`define PPBS_SCK_HALF 2'h1
// Bits per serial byte
`define PPBS_BYTE_BITS 4'h8
// Boot source encodings
`define PPBS_BOOT_ROM 1'b0
`define PPBS_BOOT_FLASH 1'b1

`endif

// File: rtl/ppbs_pkg.sv
package ppbs_pkg;
    // Serial engine states
    typedef enum logic [3:0] {
        PPBS_ST_STRAP = 4'b0001,
        PPBS_ST_IDLE = 4'b0010,
        PPBS_ST_SHIFT = 4'b0100,
        PPBS_ST_DONE = 4'b1000
    } ppbs_state_t;
endpackage

// File: rtl/ppbs_port_power.sv
// Operation
// RQ1 - Enable low turns port power on
// RQ2 - Enables and flags active low from reset
// RQ3 - Open-drain when low, push-pull when high
// RQ4 - Low flag input means over-current
// RQ5 - Flag pull-ups only in power switch mode
// RQ6 - Upstream power detect is active high
// RQ7 - Self-power input high selects self-powered
// RQ8 - Strap low ROM boot, high flash
// RQ9 - Act as serial flash master afterward
// RQ10 - Latch strap before driving select pin
`include "ppbs_defines.svh"

module ppbs_port_power (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Power control from firmware
    input wire logic [3:0] port_power_on_in,
    input wire logic polarity_high_in,
    input wire logic power_switch_mode_in,
    // Port pins
    output logic [3:0] port_power_switch_enable_out,
    output logic [3:0] port_power_switch_enable_oe_out,
    input wire logic [3:0] port_overcurrent_flag_in,
    output logic overcurrent_pullup_en_out,
    input wire logic upstream_vbus_detect_in,
    input wire logic self_power_detect_in,
    // Decoded status
    output logic [3:0] port_overcurrent_out,
    output logic upstream_vbus_present_out,
    output logic self_powered_out,
    output logic boot_from_flash_out,
    // Flash pins
    input wire logic flash_select_boot_strap_in,
    output logic flash_select_boot_strap_out,
    output logic flash_select_boot_strap_oe_out,
    output logic sck_out,
    output logic mosi_out,
    input wire logic miso_in,
    // Byte transfer request
    input wire logic xfer_start_in,
    input wire logic xfer_last_in,
    input wire logic [7:0] xfer_data_in,
    output logic [7:0] xfer_data_out,
    output logic xfer_done_out,
    output logic xfer_busy_out,
    output ppbs_pkg::ppbs_state_t state_out
);
    import ppbs_pkg::*;

    // All state of the block
    typedef struct packed {
        logic [3:0] oc_s1;          // First sync stage, over-current pins
        logic [3:0] oc_s2;          // Second sync stage
        logic [2:0] in_s1;          // First stage: vbus, self power, miso
        logic [2:0] in_s2;          // Second stage
        logic strap_s1;             // First stage of strap pin
        logic strap_s2;             // Second stage of strap pin
        logic [3:0] wait_cnt;       // Strap settle counter
        logic boot_flash;           // Latched boot source
        ppbs_state_t st;            // Serial engine state
        logic [1:0] div;            // Serial clock divider
        logic [3:0] bits;           // Bits left in byte
        logic [7:0] tx;             // Shift out register
        logic [7:0] rx;             // Shift in register
        logic last;                 // Release select after this byte
        logic [3:0] pwr_q;          // Power enable pin level
        logic [3:0] pwr_oe;         // Power enable pin drive
        logic pu_en;                // Pull-up enable
        logic [3:0] oc_flag;        // Decoded over-current
        logic vbus;                 // Upstream power present
        logic selfp;                // Self-powered setting
        logic cs;                   // Select pin level
        logic cs_oe;                // Select pin drive
        logic sck;                  // Serial clock level
        logic done;                 // Byte done pulse
        logic [7:0] rdata;          // Byte received
        logic busy;                 // Engine not idle, kept as a flop for the pin
    } ppbs_regs_t;

    ppbs_regs_t r;
    ppbs_regs_t next_r;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        // Synchronise all pin inputs; only the second stage feeds logic, so a
        // pin that moves near the clock edge cannot split one decision
        next_r.oc_s1 = port_overcurrent_flag_in;
        next_r.oc_s2 = r.oc_s1;
        next_r.in_s1 = {miso_in, self_power_detect_in, upstream_vbus_detect_in};
        next_r.in_s2 = r.in_s1;
        next_r.strap_s1 = flash_select_boot_strap_in;
        next_r.strap_s2 = r.strap_s1;
        // Flag decode, polarity chosen by firmware
        next_r.oc_flag = polarity_high_in ? r.oc_s2 : ~r.oc_s2; // RQ2 RQ4
        next_r.vbus = r.in_s2[0]; // RQ6
        next_r.selfp = r.in_s2[1]; // RQ7
        next_r.pu_en = power_switch_mode_in; // RQ5
        // Power enables per port
        for (int i = 0; i < `PPBS_NUM_PORTS; i++) begin
            if (polarity_high_in) begin
                // Push-pull, high means on
                next_r.pwr_q[i] = port_power_on_in[i]; // RQ3
                next_r.pwr_oe[i] = 1'b1; // RQ3
            end else begin
                // Open-drain: pull low for on, release for off
                next_r.pwr_q[i] = ~port_power_on_in[i]; // RQ1
                next_r.pwr_oe[i] = port_power_on_in[i]; // RQ3
            end
        end
        // Serial engine
        case (r.st)
            PPBS_ST_STRAP: begin
                // Select pin released while strap settles
                // The board pull sets the pin level that is latched here
                next_r.cs_oe = 1'b0;
                if (r.wait_cnt == `PPBS_STRAP_WAIT) begin
                    next_r.boot_flash = r.strap_s2; // RQ8 RQ10
                    next_r.st = PPBS_ST_IDLE;
                end else begin
                    next_r.wait_cnt = r.wait_cnt + 4'h1;
                end
            end
            PPBS_ST_IDLE: begin
                // Drive select only once strap is held
                // Serial clock parks low between bytes and frames
                next_r.cs_oe = 1'b1; // RQ9 RQ10
                next_r.sck = 1'b0;
                if (xfer_start_in) begin
                    next_r.cs = 1'b0; // RQ9
                    next_r.tx = xfer_data_in;
                    next_r.last = xfer_last_in;
                    next_r.bits = `PPBS_BYTE_BITS;
                    next_r.div = 2'h0;
                    next_r.st = PPBS_ST_SHIFT;
                end
            end
            PPBS_ST_SHIFT: begin
                // Mode 0: data set on falling edge, sampled on rising edge
                if (r.div == `PPBS_SCK_HALF) begin
                    // Half period over, toggle the serial clock
                    next_r.div = 2'h0;
                    if (!r.sck) begin
                        // Rising edge: the flash takes the current output bit
                        next_r.sck = 1'b1;
                    end else begin
                        // Falling edge: the synchroniser lags the input by two
                        // cycles, so its second stage now holds the bit that
                        // stood at the rising edge, before the flash moves on.
                        // This holds only while a half period is at least two cycles.
                        next_r.rx = {r.rx[6:0], r.in_s2[2]}; // RQ9
                        next_r.sck = 1'b0;
                        next_r.tx = {r.tx[6:0], 1'b0};
                        next_r.bits = r.bits - 4'h1;
                        if (r.bits == 4'h1) begin
                            next_r.st = PPBS_ST_DONE;
                        end
                    end
                end else begin
                    // Count out the half period
                    next_r.div = r.div + 2'h1;
                end
            end
            PPBS_ST_DONE: begin
                // Hand byte back, end frame if last
                // Otherwise select stays low for the next byte of the frame
                next_r.done = 1'b1;
                next_r.rdata = r.rx;
                if (r.last) begin
                    next_r.cs = 1'b1;
                end
                next_r.st = PPBS_ST_IDLE;
            end
            default: begin
                next_r.st = PPBS_ST_STRAP;
            end
        endcase
        // Synchronous reset; boot source cleared to ROM until the next strap sample
        if (!rst_b_in) begin
            next_r = '0;
            next_r.st = PPBS_ST_STRAP;
            next_r.cs = 1'b1;
            next_r.pwr_q = 4'hf; // RQ2
            next_r.pwr_oe = 4'h0; // RQ2
        end
        // Busy follows the next state so its pin comes straight from a flop
        next_r.busy = (next_r.st != PPBS_ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk_in) begin
        r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    // Pads drive a pin only while its enable is high; a released power
    // enable rests at the board pull level, which keeps the switch off.
    // The select pin is never driven during reset, so the strap level set
    // by the board cannot fight the pad while it is sampled.
    assign port_power_switch_enable_out = r.pwr_q;
    assign port_power_switch_enable_oe_out = r.pwr_oe;
    assign overcurrent_pullup_en_out = r.pu_en;
    assign port_overcurrent_out = r.oc_flag;
    assign upstream_vbus_present_out = r.vbus;
    assign self_powered_out = r.selfp;
    assign boot_from_flash_out = r.boot_flash;
    assign flash_select_boot_strap_out = r.cs;
    assign flash_select_boot_strap_oe_out = r.cs_oe;
    assign sck_out = r.sck;
    assign mosi_out = r.tx[7];
    assign xfer_data_out = r.rdata;
    assign xfer_done_out = r.done;
    assign xfer_busy_out = r.busy;
    assign state_out = r.st;
endmodule

// File: sim/ppbs_flash_model.sv
// Serial flash, mode 0: reply rotates out MSB first, received bits shift in
module ppbs_flash_model (
    input wire logic sck_in,
    input wire logic cs_b_in,
    input wire logic mosi_in,
    input wire logic [7:0] reply_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    always @(negedge cs_b_in) sh = reply_in;
    always @(posedge sck_in) rx_out = {rx_out[6:0], mosi_in};
    always @(negedge sck_in) if (!cs_b_in) sh = {sh[6:0], sh[7]};
    // Deselected line shows the inverse of the last bit
    assign miso_out = cs_b_in ? ~sh[7] : sh[7];
endmodule

// File: sim/ppbs_port_power_chk.sv
// Pin behaviour checks, bound to the block's ports
module ppbs_port_power_chk (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [3:0] port_power_on_in,
    input wire logic polarity_high_in,
    input wire logic power_switch_mode_in,
    input wire logic [3:0] port_power_switch_enable_out,
    input wire logic [3:0] port_power_switch_enable_oe_out,
    input wire logic [3:0] port_overcurrent_flag_in,
    input wire logic overcurrent_pullup_en_out,
    input wire logic upstream_vbus_detect_in,
    input wire logic self_power_detect_in,
    input wire logic [3:0] port_overcurrent_out,
    input wire logic upstream_vbus_present_out,
    input wire logic self_powered_out,
    input wire logic boot_from_flash_out,
    input wire logic flash_select_boot_strap_out,
    input wire logic flash_select_boot_strap_oe_out,
    input wire logic xfer_start_in,
    input wire logic xfer_busy_out,
    input wire logic xfer_done_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    property p_lo; !polarity_high_in |=> port_power_switch_enable_out == ~$past(port_power_on_in)
        && port_power_switch_enable_oe_out == $past(port_power_on_in); endproperty
    a_lo: assert property (p_lo) else $error("low polarity enable");
    property p_hi; polarity_high_in |=> port_power_switch_enable_out == $past(port_power_on_in)
        && port_power_switch_enable_oe_out == 4'hf; endproperty
    a_hi: assert property (p_hi) else $error("high polarity enable");
    property p_ocp; $past(rst_b_in, 2) && !polarity_high_in |=>
        port_overcurrent_out == ~$past(port_overcurrent_flag_in, 3); endproperty
    a_ocp: assert property (p_ocp) else $error("overcurrent decode");
    property p_pull; 1 |=> overcurrent_pullup_en_out == $past(power_switch_mode_in); endproperty
    a_pull: assert property (p_pull) else $error("pullup enable");
    property p_vbus; $past(rst_b_in, 2) |=>
        upstream_vbus_present_out == $past(upstream_vbus_detect_in, 3); endproperty
    a_vbus: assert property (p_vbus) else $error("vbus present");
    property p_self; $past(rst_b_in, 2) |=>
        self_powered_out == $past(self_power_detect_in, 3); endproperty
    a_self: assert property (p_self) else $error("self powered");
    property p_boot; flash_select_boot_strap_oe_out |=> $stable(boot_from_flash_out); endproperty
    a_boot: assert property (p_boot) else $error("boot source moved");
    property p_xfer; xfer_start_in && !xfer_busy_out |=>
        !flash_select_boot_strap_out ##33 xfer_done_out; endproperty
    a_xfer: assert property (p_xfer) else $error("transfer timing");
    c_xfer: cover property (xfer_done_out);
    c_hi: cover property (polarity_high_in && |port_power_on_in);
    c_ocp: cover property (|port_overcurrent_out);
endmodule
bind ppbs_port_power ppbs_port_power_chk ppbs_port_power_chk_inst (.*);

// File: sim/test_ppbs_port_power.sv
module test_ppbs_port_power;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in, rst_b_in, polarity_high_in, power_switch_mode_in, miso_in, strap;
    logic upstream_vbus_detect_in, self_power_detect_in, xfer_start_in, xfer_last_in;
    logic [3:0] port_power_on_in, port_overcurrent_flag_in, port_overcurrent_out;
    logic [3:0] port_power_switch_enable_out, port_power_switch_enable_oe_out;
    logic overcurrent_pullup_en_out, upstream_vbus_present_out, self_powered_out;
    logic boot_from_flash_out, flash_select_boot_strap_out, flash_select_boot_strap_oe_out;
    logic sck_out, mosi_out, xfer_done_out, xfer_busy_out;
    logic [7:0] xfer_data_in, xfer_data_out, rx;
    ppbs_pkg::ppbs_state_t state_out;
    int err_count = 0;
    int comparisons = 0;
    // Board pull holds the strap while the pin is released
    wire flash_select_boot_strap_in =
        flash_select_boot_strap_oe_out ? flash_select_boot_strap_out : strap;
    ppbs_port_power ppbs_port_power_inst (.*);
    ppbs_flash_model ppbs_flash_model_inst (.sck_in(sck_out), .cs_b_in(flash_select_boot_strap_in),
        .mosi_in(mosi_out), .reply_in(8'h3c), .miso_out(miso_in), .rx_out(rx));
    initial begin
        ref_clk_in = 0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rst_dut(input logic s);
        strap = s;
        rst_b_in = 0;
        tick(8);
        chk("pwr_rst", 8'hf, 8'(port_power_switch_enable_out));
        chk("oe_rst", 8'h0, 8'(port_power_switch_enable_oe_out));
        chk("cs_oe_rst", 8'h0, 8'(flash_select_boot_strap_oe_out));
        chk("busy_rst", 8'h1, 8'(xfer_busy_out));
        rst_b_in = 1;
        tick(8);
        chk("cs_oe", 8'h1, 8'(flash_select_boot_strap_oe_out));
        chk("state", 8'(ppbs_pkg::PPBS_ST_IDLE), 8'(state_out));
        chk("busy", 8'h0, 8'(xfer_busy_out));
    endtask
    task automatic xfer(input logic [7:0] d, input logic last);
        int n;
        n = 0;
        xfer_data_in = d;
        xfer_last_in = last;
        xfer_start_in = 1;
        tick(1);
        xfer_start_in = 0;
        while (xfer_done_out !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        chk("cycles", 8'h21, 8'(n));
        chk("rx", d, rx);
        chk("data", 8'h3c, xfer_data_out);
        chk("cs", 8'(last), 8'(flash_select_boot_strap_out));
        tick(1);
    endtask
    task automatic test_done;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        {rst_b_in, polarity_high_in, power_switch_mode_in, upstream_vbus_detect_in} = 4'h0;
        {self_power_detect_in, xfer_start_in, xfer_last_in, xfer_data_in} = 11'h0;
        port_power_on_in = 4'h0;
        port_overcurrent_flag_in = 4'hf;
        rst_dut(0);
        chk("boot", 8'h0, 8'(boot_from_flash_out));
        rst_dut(1);
        chk("boot", 8'h1, 8'(boot_from_flash_out));
        port_power_on_in = 4'h5;
        port_overcurrent_flag_in = 4'h6;
        upstream_vbus_detect_in = 1;
        power_switch_mode_in = 1;
        tick(4);
        chk("pwr", 8'ha, 8'(port_power_switch_enable_out));
        chk("oe", 8'h5, 8'(port_power_switch_enable_oe_out));
        chk("ocp", 8'h9, 8'(port_overcurrent_out));
        chk("pull", 8'h1, 8'(overcurrent_pullup_en_out));
        chk("vbus", 8'h1, 8'(upstream_vbus_present_out));
        chk("self", 8'h0, 8'(self_powered_out));
        xfer(8'ha5, 0);
        xfer(8'h5a, 1);
        chk("boot", 8'h1, 8'(boot_from_flash_out));
        polarity_high_in = 1;
        upstream_vbus_detect_in = 0;
        self_power_detect_in = 1;
        tick(4);
        chk("pwr", 8'h5, 8'(port_power_switch_enable_out));
        chk("oe", 8'hf, 8'(port_power_switch_enable_oe_out));
        chk("ocp", 8'h6, 8'(port_overcurrent_out));
        chk("vbus", 8'h0, 8'(upstream_vbus_present_out));
        chk("self", 8'h1, 8'(self_powered_out));
        test_done;
    end
    initial begin
        #100us;
        $display("[ERR] watchdog expected finish seen timeout");
        err_count++;
        test_done;
    end
endmodule
